// *** design/spimsp_regs.svh ***
`ifndef SPIMSP_REGS_SVH
`define SPIMSP_REGS_SVH
// Register byte offsets on the APB bus.
`define SPIMSP_CTRL_OFF     12'h000
`define SPIMSP_DATA_OFF     12'h004
// Control register field positions.
`define SPIMSP_TRF_BIT      0
`define SPIMSP_WRITE_COLLISION_FLAG_BIT     1
`define SPIMSP_SEL_BIT      2
`define SPIMSP_ORDER_BIT    3
`define SPIMSP_BUSEN_BIT    4
`define SPIMSP_MODE_LO_BIT  5
`define SPIMSP_MODE_HI_BIT  6
`define SPIMSP_CKS_BIT      7
// Control register reset value: mode bits high, the rest low.
`define SPIMSP_CTRL_RST     8'h60
// Mode field encodings.
`define SPIMSP_MODE_SLAVE   2'h0
// Serial clock half-period divisors in source ticks (mclk cycles, or alternate clock rising edges) per mode code.
`define SPIMSP_DIV_M1       8'h02
`define SPIMSP_DIV_M2       8'h08
`define SPIMSP_DIV_M3       8'h20
// Bits per transfer.
`define SPIMSP_BITS         4'h8
`endif

// *** design/spimsp_pkg.sv ***
package spimsp_pkg;
   // Control register laid out as packed fields, high bit first.
   typedef struct packed {
      logic       clock_source_select;
      logic [1:0] mode;
      logic       bus_en;
      logic       order;
      logic       sel_en;
      logic       write_collision_flag;
      logic       transfer_done_flag;
   } spimsp_ctrl_t;

   // Serial engine states.
   typedef enum logic [1:0] {
      SPIMSP_IDLE  = 2'b00,
      SPIMSP_LEAD  = 2'b01,
      SPIMSP_TRAIL = 2'b10
   } spimsp_state_t;

   // Pad drive for one pin: output level and output enable.
   typedef struct packed {
      logic o;
      logic oe;
   } spimsp_pad_t;
endpackage

// *** design/spimsp_port.sv ***
`include "spimsp_regs.svh"

// Summary of operation
// R1 - Four lines: data in, data out, clock, select; shared pins when option on.
// R2 - Select enable 1 makes select line active; 0 leaves it floating.
// R3 - Reset: control clock source 0, mode bits 1, others 0; data undefined.
// R4 - Data write loads shift buffer; read returns separately latched receive value.
// R5 - Master mode: data write starts clocks and shifting automatically.
// R6 - Transfer done sets completion flag, which requests the port interrupt.
// R7 - Slave mode shifts only on clock edges from the external master.
// R8 - Bus enable 0 floats select, data in, data out and clock.
// R9 - Bus enabled: data in is an input, data out idles high.
// R10 - Master clock idles at polarity option; slave clock pin floats.
// R11 - Master sources the serial clock; slave takes it from external master.
// R12 - Mode 00 selects slave; clock source bit ignored there.
// R13 - Other mode codes select master and baud rate; rates unconfirmed.
// R14 - In master mode, clock source bit selects the clock generator source.
// R15 - Bit order bit selects MSB or LSB first on both ends.
// R16 - Received bits gather in shift buffer, copied out after whole transfer.
// R17 - Data write during transfer is blocked, sets collision flag; software clears.
// R18 - An option enables or disables collision detection entirely.
// R19 - An option can disable select enable so it has no effect.
// R20 - Serial transfers keep running in processor power down.
// R21 - Software writes, checks collision, waits completion, reads, clears, repeats.
// R22 - Lines should be low before the first data write after enabling.
// R23 - Eight bits per transfer; flag set after eighth bit sampled.
module spimsp_port (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        opt_serial_pins,
   input  wire logic        opt_clk_pol,
   input  wire logic        opt_write_collision_flag_en,
   input  wire logic        opt_sel_en,
   input  wire logic        alt_clk,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_in_line,
   input  wire logic        sclk_i,
   input  wire logic        select_line_i,
   output logic             serial_out_line_o,
   output logic             serial_out_line_oe,
   output logic             sclk_o,
   output logic             sclk_oe,
   output logic             select_line_o,
   output logic             select_line_oe,
   output logic             serial_port_interrupt
);

   spimsp_pkg::spimsp_ctrl_t  ctrl_reg;
   spimsp_pkg::spimsp_state_t state_reg;
   logic [7:0]  shift_buffer;
   logic [7:0]  rx_data_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  div_cnt_reg;
   logic        out_bit_reg;
   logic [2:0]  sclk_sync_reg;
   logic [1:0]  sdi_sync_reg;
   logic [1:0]  ssl_sync_reg;
   logic [1:0]  alt_sync_reg;
   logic        alt_prev_reg;
   logic        pready_reg;

   // Input synchronisers; only the second stage onward is looked at.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclk_sync_reg <= 3'h0;
         sdi_sync_reg  <= 2'h0;
         ssl_sync_reg  <= 2'h3;
         alt_sync_reg  <= 2'h0;
         alt_prev_reg  <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
         sdi_sync_reg  <= {sdi_sync_reg[0], serial_in_line};
         ssl_sync_reg  <= {ssl_sync_reg[0], select_line_i};
         alt_sync_reg  <= {alt_sync_reg[0], alt_clk};
         alt_prev_reg  <= alt_sync_reg[1];
      end
   end

   // Derived configuration. The select enable is forced off by option.
   wire sel_active = ctrl_reg.sel_en & opt_sel_en; // R19
   wire enabled    = ctrl_reg.bus_en & opt_serial_pins; // R1
   wire is_master  = ctrl_reg.mode != `SPIMSP_MODE_SLAVE; // R12 R13
   wire sdi_s      = sdi_sync_reg[1];
   wire ssl_ok     = ~sel_active | ~ssl_sync_reg[1]; // R2

   // External clock edges in slave mode; leading edge leaves idle level.
   wire ext_rise   = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   wire ext_fall   = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   wire ext_lead   = opt_clk_pol ? ext_fall : ext_rise;
   wire ext_trail  = opt_clk_pol ? ext_rise : ext_fall;

   // Master tick source: mclk, or the rising edges of the alternate clock.
   wire alt_tick   = alt_sync_reg[1] & ~alt_prev_reg;
   wire src_tick   = ctrl_reg.clock_source_select ? alt_tick : 1'b1; // R14
   wire [7:0] div_lim = (ctrl_reg.mode == 2'h1) ? `SPIMSP_DIV_M1 :
                        (ctrl_reg.mode == 2'h2) ? `SPIMSP_DIV_M2 :
                                                  `SPIMSP_DIV_M3; // R13
   wire half_tick  = src_tick && (div_cnt_reg == div_lim - 8'h01);

   // Engine strobes: master uses its own divider, slave the external edges.
   wire busy       = state_reg != spimsp_pkg::SPIMSP_IDLE;
   wire do_sample  = busy && (is_master ? (half_tick &&
                     state_reg == spimsp_pkg::SPIMSP_LEAD) :
                     (ext_lead && ssl_ok)); // R7 R11
   wire do_shift   = busy && (is_master ? (half_tick &&
                     state_reg == spimsp_pkg::SPIMSP_TRAIL) :
                     (ext_trail && ssl_ok)); // R7
   wire last_bit   = bit_cnt_reg == `SPIMSP_BITS - 4'h1; // R23

   // APB decode; registers answer with zero wait states.
   wire acc        = psel & penable;
   wire hit_ctrl   = paddr == `SPIMSP_CTRL_OFF;
   wire hit_data   = paddr == `SPIMSP_DATA_OFF;
   wire wr_ctrl    = acc & pwrite & hit_ctrl & pready_reg;
   wire wr_data    = acc & pwrite & hit_data & pready_reg;
   wire collide    = wr_data & busy; // R17
   wire load       = wr_data & ~busy & enabled; // R4 R22
   wire done       = do_sample & last_bit; // R6 R23

   // Bit placement follows the order bit: MSB first when it is 0.
   wire tx_bit     = ctrl_reg.order ? shift_buffer[0] : shift_buffer[7]; // R15
   wire [7:0] shifted = ctrl_reg.order ? {sdi_s, shift_buffer[7:1]} :
                                         {shift_buffer[6:0], sdi_s}; // R15

   // Control register; hardware set beats software clear on both flags.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= `SPIMSP_CTRL_RST; // R3
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0];
         end
         if (done) begin
            ctrl_reg.transfer_done_flag <= 1'b1; // R6
         end
         if (collide && opt_write_collision_flag_en) begin
            ctrl_reg.write_collision_flag <= 1'b1; // R17 R18
         end
      end
   end

   // Serial engine. It runs on mclk alone so power down does not stop it.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg    <= spimsp_pkg::SPIMSP_IDLE;
         shift_buffer <= 8'h00;
         rx_data_reg  <= 8'h00;
         bit_cnt_reg  <= 4'h0;
         div_cnt_reg  <= 8'h00;
         out_bit_reg  <= 1'b1;
      end else begin
         if (src_tick) begin
            div_cnt_reg <= half_tick ? 8'h00 : div_cnt_reg + 8'h01;
         end
         case (state_reg)
            spimsp_pkg::SPIMSP_IDLE: begin
               out_bit_reg <= 1'b1; // R9
               bit_cnt_reg <= 4'h0;
               div_cnt_reg <= 8'h00;
               if (load) begin
                  shift_buffer <= pwdata[7:0]; // R4 R5
                  out_bit_reg  <= ctrl_reg.order ? pwdata[0] : pwdata[7];
                  state_reg    <= spimsp_pkg::SPIMSP_LEAD; // R5 R20
               end
            end
            spimsp_pkg::SPIMSP_LEAD: begin
               if (do_sample) begin
                  shift_buffer <= shifted; // R16
                  // The last bit still gets its trailing half so the far
                  // side sees eight full clock pulses.
                  if (last_bit) begin
                     rx_data_reg <= shifted; // R16
                  end
                  state_reg    <= spimsp_pkg::SPIMSP_TRAIL; // R23
                  bit_cnt_reg  <= bit_cnt_reg + 4'h1; // R23
               end
            end
            spimsp_pkg::SPIMSP_TRAIL: begin
               if (do_shift) begin
                  if (bit_cnt_reg == `SPIMSP_BITS) begin
                     state_reg   <= spimsp_pkg::SPIMSP_IDLE; // R23
                  end else begin
                     out_bit_reg <= tx_bit;
                     state_reg   <= spimsp_pkg::SPIMSP_LEAD;
                  end
               end
            end
            default: begin
               state_reg <= spimsp_pkg::SPIMSP_IDLE;
            end
         endcase
         if (!enabled) begin
            state_reg <= spimsp_pkg::SPIMSP_IDLE;
         end
      end
   end

   // Pad drive values; clock toggles off idle level between lead and trail.
   wire sclk_lvl   = (state_reg == spimsp_pkg::SPIMSP_TRAIL) ^ opt_clk_pol;
   wire drv_master = enabled & is_master; // R10 R11
   wire sel_drive  = drv_master & sel_active; // R2
   wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_reg} :
                        hit_data ? {24'h0, rx_data_reg} : 32'h0; // R4

   // Output flops, so every pin and bus output comes from a register.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata                <= 32'h0;
         pready_reg            <= 1'b0;
         pslverr               <= 1'b0;
         serial_out_line_o     <= 1'b1;
         serial_out_line_oe    <= 1'b0;
         sclk_o                <= 1'b0;
         sclk_oe               <= 1'b0;
         select_line_o         <= 1'b1;
         select_line_oe        <= 1'b0;
         serial_port_interrupt <= 1'b0;
      end else begin
         pready_reg            <= psel & ~penable;
         prdata                <= (psel & ~penable) ? rd_mux : prdata;
         pslverr               <= psel & ~penable & ~hit_ctrl & ~hit_data;
         serial_out_line_o     <= out_bit_reg; // R9
         serial_out_line_oe    <= enabled; // R8 R9
         sclk_o                <= sclk_lvl; // R10
         sclk_oe               <= drv_master; // R8 R10
         select_line_o         <= ~busy;
         select_line_oe        <= sel_drive; // R2 R8
         serial_port_interrupt <= ctrl_reg.transfer_done_flag; // R6
      end
   end
   assign pready = pready_reg;

   // Collision sets the flag on the next cycle when detection is enabled.
   property p_collision;
      @(posedge mclk) disable iff (!nrst)
         (collide && opt_write_collision_flag_en) |=> ctrl_reg.write_collision_flag;
   endproperty
   a_collision: assert property (p_collision) // R17
      else $error("collision flag not set");

   // A blocked write never changes the shift buffer.
   property p_blocked;
      @(posedge mclk) disable iff (!nrst)
         collide && !do_sample |=> shift_buffer == $past(shift_buffer);
   endproperty
   a_blocked: assert property (p_blocked) // R17
      else $error("blocked write altered buffer");

   // Done copies the shift result into the readable register.
   property p_copy;
      @(posedge mclk) disable iff (!nrst)
         done |=> rx_data_reg == shift_buffer && ctrl_reg.transfer_done_flag;
   endproperty
   a_copy: assert property (p_copy) // R16
      else $error("receive copy wrong");

   // Interrupt follows the completion flag one cycle later.
   property p_irq;
      @(posedge mclk) disable iff (!nrst)
         ctrl_reg.transfer_done_flag |=> serial_port_interrupt;
   endproperty
   a_irq: assert property (p_irq) // R6
      else $error("interrupt missing");

   // A disabled bus floats every pin.
   property p_float;
      @(posedge mclk) disable iff (!nrst)
         !enabled |=> !serial_out_line_oe && !sclk_oe && !select_line_oe;
   endproperty
   a_float: assert property (p_float) // R8
      else $error("pins driven while disabled");

   // Slave never drives the clock.
   property p_slave_clk;
      @(posedge mclk) disable iff (!nrst)
         !is_master |=> !sclk_oe;
   endproperty
   a_slave_clk: assert property (p_slave_clk) // R10
      else $error("slave drives clock");

   // A master load leaves idle on the next edge.
   property p_start;
      @(posedge mclk) disable iff (!nrst)
         load && is_master |=> state_reg == spimsp_pkg::SPIMSP_LEAD;
   endproperty
   a_start: assert property (p_start) // R5
      else $error("transfer did not start");

   // Bit count never passes eight.
   property p_bits;
      @(posedge mclk) disable iff (!nrst)
         bit_cnt_reg <= `SPIMSP_BITS;
   endproperty
   a_bits: assert property (p_bits) // R23
      else $error("bit count overflow");

endmodule

// *** verification/spimsp_peer.sv ***
// Far-side serial device: a slave when the port is master, else a master.
module spimsp_peer (
   input  wire logic       drive_clk,
   input  wire logic       lsb_first,
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   input  wire logic       sclk_in,
   input  wire logic       from_dut,
   output logic            to_dut,
   output logic            sclk_out,
   output logic            sel_n_out,
   output logic [7:0]      rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;

   initial begin
      sclk_out = 1'b0;
      sel_n_out = 1'b1;
      sh = 8'hFF;
      rx_byte = 8'h00;
   end

   // Current outgoing bit follows the chosen order.
   assign to_dut = lsb_first ? sh[0] : sh[7];

   // As master the clock stands still outside the frame, phase unrelated.
   always @(posedge start) begin
      sh = tx_byte;
      if (drive_clk) begin
         #37 sel_n_out = 1'b0;
         #400;
         repeat (16) begin
            #100 sclk_out = ~sclk_out;
         end
         #400 sel_n_out = 1'b1;
      end
   end

   // Clock idles low: sample on the rising edge, shift on the falling edge.
   always @(posedge sclk_in) begin
      rx_byte = lsb_first ? {from_dut, rx_byte[7:1]} : {rx_byte[6:0], from_dut};
   end
   always @(negedge sclk_in) begin
      sh = lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
   end
endmodule

// *** verification/spi_master_slave_port_tb.sv ***
`include "spimsp_regs.svh"

module spi_master_slave_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        nrst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        sdo_o, sdo_oe, sck_o, sck_oe, sel_o, sel_oe, irq;
   logic        p_start, p_drv, p_lsb, p_sdi, p_sck, p_sel_n;
   logic [7:0]  p_tx, p_rx;
   int          err_count, compares, cyc;
   // Shared pins resolve from the port's output enables alone.
   wire sck_w = sck_oe ? sck_o : p_sck;
   wire sel_w = sel_oe ? sel_o : p_sel_n;
   wire sdo_w = sdo_oe ? sdo_o : ~sdo_o;

   spimsp_port dut (.mclk(mclk), .nrst(nrst), .opt_serial_pins(1'b1),
      .opt_clk_pol(1'b0), .opt_write_collision_flag_en(1'b1), .opt_sel_en(1'b1),
      .alt_clk(1'b0), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_in_line(p_sdi), .sclk_i(sck_w),
      .select_line_i(sel_w), .serial_out_line_o(sdo_o),
      .serial_out_line_oe(sdo_oe), .sclk_o(sck_o), .sclk_oe(sck_oe),
      .select_line_o(sel_o), .select_line_oe(sel_oe),
      .serial_port_interrupt(irq));
   spimsp_peer peer (.drive_clk(p_drv), .lsb_first(p_lsb), .start(p_start),
      .tx_byte(p_tx), .sclk_in(sck_w), .from_dut(sdo_w), .to_dut(p_sdi),
      .sclk_out(p_sck), .sel_n_out(p_sel_n), .rx_byte(p_rx));

   always #12.5 mclk = ~mclk;

   // Cut a hang short; the ceiling is several times the expected run.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 10000) begin
         err_count++;
         results();
      end
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk({31'h0, irq}, 32'h1);
   endtask

   task automatic reset_check();
      apb(1'b0, `SPIMSP_CTRL_OFF, 32'h0);
      chk(q, 32'h60);
      chk({29'h0, sdo_oe, sck_oe, sel_oe}, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk({q[30:0], e}, 32'h1);
   endtask

   // A second data write in mid-transfer is blocked and flagged.
   task automatic collide();
      apb(1'b1, `SPIMSP_CTRL_OFF, 32'h30);
      // Pad outputs are registered: let them settle before looking.
      repeat (2) @(posedge mclk);
      chk({29'h0, sel_oe, sdo_oe, sdo_o}, 32'h3);
      p_drv <= 1'b0;
      p_lsb <= 1'b0;
      apb(1'b1, `SPIMSP_DATA_OFF, 32'hA5);
      apb(1'b1, `SPIMSP_DATA_OFF, 32'h0F);
      wait_irq();
      apb(1'b0, `SPIMSP_CTRL_OFF, 32'h0);
      chk(q, 32'h33);
      chk({24'h0, p_rx}, 32'hA5);
      apb(1'b1, `SPIMSP_CTRL_OFF, 32'h30);
      apb(1'b0, `SPIMSP_CTRL_OFF, 32'h0);
      chk(q, 32'h30);
   endtask

   // Full byte exchange with the peer in the role the mode leaves to it.
   task automatic run(input logic [7:0] ctl, input logic [7:0] tx,
                      input logic [7:0] ptx, input logic slave);
      apb(1'b1, `SPIMSP_CTRL_OFF, {24'h0, ctl});
      repeat (2) @(posedge mclk);
      chk({30'h0, sck_oe, sck_o}, slave ? 32'h0 : 32'h2);
      p_drv <= slave;
      p_lsb <= ctl[3];
      p_tx <= ptx;
      apb(1'b1, `SPIMSP_DATA_OFF, {24'h0, tx});
      p_start <= 1'b1;
      @(posedge mclk);
      p_start <= 1'b0;
      wait_irq();
      apb(1'b0, `SPIMSP_CTRL_OFF, 32'h0);
      chk(q, {24'h0, ctl | 8'h01});
      apb(1'b0, `SPIMSP_DATA_OFF, 32'h0);
      chk(q, {24'h0, ptx});
      chk({24'h0, p_rx}, {24'h0, tx});
      apb(1'b1, `SPIMSP_CTRL_OFF, {24'h0, ctl});
      repeat (24) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
   endtask

   // A disabled port floats every line and ignores data writes.
   task automatic disabled();
      apb(1'b1, `SPIMSP_CTRL_OFF, 32'h0);
      repeat (2) @(posedge mclk);
      chk({29'h0, sdo_oe, sck_oe, sel_oe}, 32'h0);
      apb(1'b1, `SPIMSP_DATA_OFF, 32'h55);
      apb(1'b0, `SPIMSP_CTRL_OFF, 32'h0);
      chk(q, 32'h0);
   endtask

   initial begin
      {nrst, psel, penable, pwrite, p_start, p_drv, p_lsb} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      p_tx = 8'h00;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      reset_check();
      collide();
      run(8'h54, 8'hC3, 8'h3C, 1'b0);
      run(8'h7C, 8'h81, 8'h12, 1'b0);
      run(8'h94, 8'h5A, 8'hE7, 1'b1);
      run(8'h1C, 8'h01, 8'h80, 1'b1);
      disabled();
      results();
   end
endmodule
